//--- hw/adsp_port.sv
/*
  Serial port of a 24-bit converter: chip select gating, ready signalling,
  result saturation and load, idle timeout, command byte delivery.
  Assumes pins are asynchronous to sys_clk and sclk is well below sys_clk/4;
  conv_valid, conv_raw, cmd_busy, tx_* and timeout_en come from sys_clk logic.
*/
`timescale 1ns/100ps
`include "adsp_map.svh"

module adsp_port #(
  parameter int TMO_CYC = `ADSP_TMO_CYC
) (
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst_b,
  // Serial pins
  input  wire logic                    cs_n,
  input  wire logic                    sclk,
  input  wire logic                    din,
  output logic                         shared_out_ready_pin,
  output logic                         shared_out_ready_oe_n,
  output logic                         result_ready_n,
  // Converter side
  input  wire logic                    conv_valid,
  input  wire logic [`ADSP_RAW_W-1:0]  conv_raw,
  input  wire logic                    continuous_mode,
  // Command side
  input  wire logic                    timeout_en,
  input  wire logic                    cmd_busy,
  input  wire logic [`ADSP_BYTE_W-1:0] tx_byte,
  input  wire logic                    tx_load,
  output logic [`ADSP_BYTE_W-1:0]      rx_byte,
  output logic                         rx_valid,
  output logic                         serial_reset
);
  import adsp_pkg::*;

  localparam logic [`ADSP_LEAD_W-1:0] LEAD_LAST = `ADSP_LEAD_W'(`ADSP_LEAD_CYC - 1);
  localparam logic [`ADSP_TMO_W-1:0]  TMO_LAST  = `ADSP_TMO_W'(TMO_CYC - 1);

  adsp_top_t                s;
  adsp_top_t                next_s;
  logic                     sel;
  logic                     rise;
  logic                     fall;
  logic                     expire;
  logic                     load;
  logic [`ADSP_WORD_W-1:0]  load_data;

  adsp_if sif ();

  adsp_shift u_shift (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .sif     (sif)
  );

  // ----------------------------------------------------------------
  // Saturation to the output code range
  // ----------------------------------------------------------------
  function automatic logic [`ADSP_WORD_W-1:0] sat(input logic [`ADSP_RAW_W-1:0] raw);
    logic [3:0] top;
    top = raw[`ADSP_RAW_W-2:`ADSP_WORD_W-1];
    if (!raw[`ADSP_RAW_W-1] && top != 4'h0) begin
      sat = `ADSP_CODE_MAX;
    end else if (raw[`ADSP_RAW_W-1] && top != 4'hF) begin
      sat = `ADSP_CODE_MIN;
    end else begin
      sat = raw[`ADSP_WORD_W-1:0];
    end
  endfunction : sat

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.cs_s1   = cs_n;
    next_s.cs_s2   = s.cs_s1;
    next_s.sclk_s1 = sclk;
    next_s.sclk_s2 = s.sclk_s1;
    next_s.sclk_q  = s.sclk_s2;
    next_s.din_s1  = din;
    next_s.din_s2  = s.din_s1;

    sel  = !s.cs_s2;
    rise = sel && s.sclk_s2 && !s.sclk_q;
    fall = sel && !s.sclk_s2 && s.sclk_q;

    expire = 1'b0;
    if (!timeout_en || !sel || sif.byte_valid) begin
      next_s.tmo_cnt = '0;
    end else if (s.tmo_cnt == TMO_LAST) begin
      next_s.tmo_cnt = '0;
      expire = 1'b1;
    end else begin
      next_s.tmo_cnt = s.tmo_cnt + 16'h1;
    end
    next_s.srst = expire;

    // zero byte dropped outside a command
    next_s.rx_valid = sif.byte_valid && (cmd_busy || sif.byte_data != `ADSP_CMD_NOP);
    if (sif.byte_valid) begin
      next_s.rx_byte = sif.byte_data;
    end

    load      = 1'b0;
    load_data = {tx_byte, 16'h0};
    if (tx_load) begin
      load = 1'b1;
    end

    unique case (s.rdy_st)
      RDY_WAIT: begin
        if (rise && continuous_mode && !s.ready_n) begin
          next_s.ready_n = 1'b1;
        end
      end
      RDY_LEAD: begin
        if (s.lead_cnt == LEAD_LAST) begin
          next_s.ready_n = 1'b0;
          next_s.rdy_st  = RDY_WAIT;
          if (!cmd_busy && !tx_load) begin
            load      = 1'b1;
            load_data = s.pend;
          end
        end else begin
          next_s.lead_cnt = s.lead_cnt + 5'h1;
        end
      end
    endcase

    if (conv_valid) begin
      next_s.pend     = sat(conv_raw);
      next_s.ready_n  = 1'b1;
      next_s.lead_cnt = '0;
      next_s.rdy_st   = RDY_LEAD;
    end

    next_s.pin_oe_n = !sel;
    // shared pin mirrors ready until shifting
    // with chip select tied low, pin keeps the output bit after a read until the next load or timeout
    next_s.pin = (sif.started && !load) ? sif.out_bit : next_s.ready_n;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s          <= '0;
      s.cs_s1    <= 1'b1;
      s.cs_s2    <= 1'b1;
      s.ready_n  <= 1'b1;
      s.pin      <= 1'b1;
      s.pin_oe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Shifter and outputs
  // ----------------------------------------------------------------
  // deselect or timeout clears the shifter
  assign sif.clr       = s.cs_s2 || s.srst;
  assign sif.rise      = rise;
  assign sif.fall      = fall;
  assign sif.din_bit   = s.din_s2;
  assign sif.load      = load;
  assign sif.load_data = load_data;

  // ready pin independent of chip select
  assign result_ready_n        = s.ready_n;
  assign shared_out_ready_pin  = s.pin;
  assign shared_out_ready_oe_n = s.pin_oe_n;
  assign rx_byte               = s.rx_byte;
  assign rx_valid              = s.rx_valid;
  assign serial_reset          = s.srst;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  a_hiz_deselect: assert property (s.cs_s2 |=> shared_out_ready_oe_n)
    else $error("shared pin driven while deselected");
  a_no_edge_deselect: assert property (s.cs_s2 |=> sif.bit_cnt == 3'h0)
    else $error("shifter counted while deselected");
  a_lead_fall: assert property ($fell(result_ready_n) |-> $past(conv_valid, 25))
    else $error("ready fell without 24 cycle lead");
  a_lead_high: assert property (conv_valid |=> result_ready_n[*8])
    else $error("ready not high during lead");
  a_cont_release: assert property ((rise && continuous_mode && !result_ready_n
    && s.rdy_st == RDY_WAIT && !conv_valid) |=> result_ready_n)
    else $error("ready not released by first rising edge");
  a_single_hold: assert property ((!continuous_mode && !result_ready_n
    && s.rdy_st == RDY_WAIT && !conv_valid) |=> !result_ready_n)
    else $error("ready rose without new result");
  a_pin_with_ready: assert property (($fell(result_ready_n) && $past(load)
    && !shared_out_ready_oe_n) |-> !shared_out_ready_pin)
    else $error("shared pin did not fall with ready");
  a_sat_high: assert property ((conv_valid && !conv_raw[27] && conv_raw[26:23] != 4'h0)
    |=> s.pend == `ADSP_CODE_MAX)
    else $error("positive overrange not clipped");
  a_sat_low: assert property ((conv_valid && conv_raw[27] && conv_raw[26:23] != 4'hF)
    |=> s.pend == `ADSP_CODE_MIN)
    else $error("negative overrange not clipped");
  a_busy_no_load: assert property ((s.rdy_st == RDY_LEAD && s.lead_cnt == LEAD_LAST
    && cmd_busy && !tx_load) |-> !sif.load)
    else $error("result loaded during register command");
  a_nop_dropped: assert property ((sif.byte_valid && !cmd_busy
    && sif.byte_data == `ADSP_CMD_NOP) |=> !rx_valid)
    else $error("zero command byte forwarded");
  a_tmo_fires: assert property ((timeout_en && !s.cs_s2 && !sif.byte_valid
    && s.tmo_cnt == TMO_LAST) |=> serial_reset ##1 sif.bit_cnt == 3'h0)
    else $error("timeout did not reset the port");
  a_tmo_enable: assert property (serial_reset |-> $past(timeout_en))
    else $error("timeout fired while disabled");
  a_oe_selected: assert property (!s.cs_s2 |=> !shared_out_ready_oe_n)
    else $error("shared pin not driven while selected");
  a_ready_deselect: assert property ((s.cs_s2 && !result_ready_n
    && s.rdy_st == RDY_WAIT && !conv_valid) |=> !result_ready_n)
    else $error("ready changed by deselect");
  a_result_load: assert property ((s.rdy_st == RDY_LEAD && s.lead_cnt == LEAD_LAST
    && !cmd_busy && !tx_load) |-> sif.load && sif.load_data == s.pend)
    else $error("new result not loaded when ready fell");
  a_lead_start: assert property (conv_valid |=> s.rdy_st == RDY_LEAD && s.lead_cnt == '0)
    else $error("new result did not restart the lead");
  a_tx_load: assert property (tx_load
    |-> sif.load && sif.load_data == {tx_byte, 16'h0000})
    else $error("register byte not loaded");
  a_code_pass: assert property ((conv_valid
    && (conv_raw[27:23] == 5'h00 || conv_raw[27:23] == 5'h1F))
    |=> {4'h0, s.pend} == ($past(conv_raw) & 28'h0FFFFFF))
    else $error("in-range result altered");
  a_lead_count: assert property ((s.rdy_st == RDY_LEAD && s.lead_cnt != LEAD_LAST
    && !conv_valid) |=> s.rdy_st == RDY_LEAD && result_ready_n)
    else $error("lead window cut short");
  a_cont_hold: assert property ((continuous_mode && !result_ready_n && !rise
    && s.rdy_st == RDY_WAIT && !conv_valid) |=> !result_ready_n)
    else $error("ready rose without rising edge");
  a_pin_bit: assert property ((sif.started && !sif.load)
    |=> shared_out_ready_pin == $past(sif.out_bit))
    else $error("shared pin not showing output bit");
  a_rx_forward: assert property ((sif.byte_valid && sif.byte_data != `ADSP_CMD_NOP)
    |=> rx_valid && rx_byte == $past(sif.byte_data))
    else $error("command byte not forwarded");
  a_rx_quiet: assert property (!sif.byte_valid |=> !rx_valid && $stable(rx_byte))
    else $error("byte output changed without a byte");
  a_tmo_idle: assert property (!timeout_en |=> s.tmo_cnt == '0)
    else $error("timeout counted while disabled");
  a_tmo_byte: assert property (sif.byte_valid |=> s.tmo_cnt == '0)
    else $error("timeout not restarted by a byte");
  a_tmo_clear: assert property (serial_reset |=> sif.bit_cnt == 3'h0 && !serial_reset)
    else $error("timeout did not clear the shifter");

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  c_result_read: cover property ($fell(result_ready_n) ##[1:1000] rise);
  c_timeout: cover property (serial_reset);
  c_cmd_byte: cover property (rx_valid && rx_byte != `ADSP_CMD_NOP);
  c_overwrite: cover property (!result_ready_n ##1 conv_valid);
  c_single: cover property (!continuous_mode && $fell(result_ready_n));

endmodule : adsp_port

//--- hw/adsp_map.svh
/*
  Constants of the converter serial port: widths, codes, timing counts.
  Assumes the core clock that times the ready lead also runs sys_clk.
*/
`ifndef ADSP_MAP_SVH
`define ADSP_MAP_SVH
`define ADSP_WORD_W    24
`define ADSP_BYTE_W    8
`define ADSP_RAW_W     28
`define ADSP_BITCNT_W  3
`define ADSP_CODE_MAX  24'h7FFFFF
`define ADSP_CODE_MIN  24'h800000
`define ADSP_CMD_NOP   8'h00
`define ADSP_SYS_NS    8
`define ADSP_TCLK_NS   8
`define ADSP_LEAD_TCLK 24
`define ADSP_LEAD_CYC  ((`ADSP_LEAD_TCLK*`ADSP_TCLK_NS+`ADSP_SYS_NS-1)/`ADSP_SYS_NS)
`define ADSP_LEAD_W    5
`define ADSP_TMO_TCLK  32768
`define ADSP_TMO_CYC   ((`ADSP_TMO_TCLK*`ADSP_TCLK_NS)/`ADSP_SYS_NS)
`define ADSP_TMO_W     16
`endif

//--- hw/adsp_pkg.sv
/*
  Types of the converter serial port: ready states and state records.
  Assumes adsp_map.svh is on the include path.
*/
`include "adsp_map.svh"
package adsp_pkg;

  typedef enum logic [0:0] {RDY_WAIT, RDY_LEAD} adsp_rdy_t;

  typedef struct packed {
    logic                     cs_s1;
    logic                     cs_s2;
    logic                     sclk_s1;
    logic                     sclk_s2;
    logic                     sclk_q;
    logic                     din_s1;
    logic                     din_s2;
    adsp_rdy_t                rdy_st;
    logic [`ADSP_LEAD_W-1:0]  lead_cnt;
    logic [`ADSP_WORD_W-1:0]  pend;
    logic [`ADSP_TMO_W-1:0]   tmo_cnt;
    logic                     ready_n;
    logic                     pin;
    logic                     pin_oe_n;
    logic [`ADSP_BYTE_W-1:0]  rx_byte;
    logic                     rx_valid;
    logic                     srst;
  } adsp_top_t;

  typedef struct packed {
    logic [`ADSP_BYTE_W-1:0]   rx_sh;
    logic [`ADSP_BITCNT_W-1:0] bit_cnt;
    logic [`ADSP_WORD_W-1:0]   tx_sh;
    logic                      started;
    logic                      byte_valid;
    logic [`ADSP_BYTE_W-1:0]   byte_data;
  } adsp_shf_t;

endpackage : adsp_pkg

//--- hw/adsp_if.sv
/*
  Carrier between the port control and the bit shifter.
  Assumes both ends run on sys_clk.
*/
`timescale 1ns/100ps
`include "adsp_map.svh"
interface adsp_if;
  logic                      clr;
  logic                      rise;
  logic                      fall;
  logic                      din_bit;
  logic                      load;
  logic [`ADSP_WORD_W-1:0]   load_data;
  logic                      byte_valid;
  logic [`ADSP_BYTE_W-1:0]   byte_data;
  logic                      out_bit;
  logic                      started;
  logic [`ADSP_BITCNT_W-1:0] bit_cnt;

  modport ctl (output clr, rise, fall, din_bit, load, load_data,
               input byte_valid, byte_data, out_bit, started, bit_cnt);
  modport shf (input clr, rise, fall, din_bit, load, load_data,
               output byte_valid, byte_data, out_bit, started, bit_cnt);
endinterface : adsp_if

//--- hw/adsp_shift.sv
/*
  Bit shifter: collects input bytes on falling edges, shifts the output word
  on rising edges. Assumes edges arrive as one-cycle sys_clk strobes.
*/
`timescale 1ns/100ps
module adsp_shift (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // Control side
  adsp_if.shf       sif
);
  import adsp_pkg::*;

  adsp_shf_t s;
  adsp_shf_t next_s;

  // ----------------------------------------------------------------
  // Shift logic
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.byte_valid = 1'b0;
    if (sif.clr) begin
      next_s = '0;
    end else begin
      if (sif.load) begin
        next_s.tx_sh   = sif.load_data;
        next_s.started = 1'b0;
      end
      if (sif.fall) begin
        next_s.rx_sh   = {s.rx_sh[`ADSP_BYTE_W-2:0], sif.din_bit};
        next_s.bit_cnt = s.bit_cnt + 3'h1;
        if (s.bit_cnt == 3'h7) begin
          next_s.byte_valid = 1'b1;
          next_s.byte_data  = {s.rx_sh[`ADSP_BYTE_W-2:0], sif.din_bit};
        end
      end
      if (sif.rise && !sif.load) begin
        if (!s.started) begin
          next_s.started = 1'b1;
        end else begin
          next_s.tx_sh = {s.tx_sh[`ADSP_WORD_W-2:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sif.byte_valid = s.byte_valid;
  assign sif.byte_data  = s.byte_data;
  assign sif.out_bit    = s.tx_sh[`ADSP_WORD_W-1];
  assign sif.started    = s.started;
  assign sif.bit_cnt    = s.bit_cnt;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_shift_on_rise: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (sif.rise && s.started && !sif.clr && !sif.load) |=> s.tx_sh == ($past(s.tx_sh) << 1))
    else $error("output word did not shift on rising edge");
  a_byte_after_eight: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (sif.fall && !sif.clr && s.bit_cnt == 3'h7) |=> s.byte_valid && s.bit_cnt == 3'h0)
    else $error("byte not completed on eighth falling edge");

endmodule : adsp_shift

//--- tb/adsp_host.sv
/*
  Host model: serial master in mode one, driving select, clock and data in.
  Assumes the bench resolves the shared pin into sdo and calls the tasks.
*/
`timescale 1ns/100ps
module adsp_host (
  // Serial pins
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  input  wire logic sdo
);
  localparam realtime HALF = 62.5;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end

  task automatic sel(input logic v);
    cs_n = v;
    #100;
  endtask : sel

  // clock idles low, data set on rise, taken on fall
  task automatic shift(input int n, input logic [23:0] tx, output logic [23:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b1;
      din  = tx[i];
      #HALF;
      rx   = {rx[22:0], sdo};
      sclk = 1'b0;
      #HALF;
    end
    din = 1'b0;
  endtask : shift
endmodule : adsp_host

//--- tb/adsp_port_test.sv
/*
  Self-checking bench of the converter serial port.
  Assumes the host model drives the pins and sys_clk runs at 125 MHz.
*/
`timescale 1ns/100ps
`include "adsp_map.svh"
module adsp_port_test;
  logic                    sys_clk = 1'b0;
  logic                    rst_b = 1'b0;
  logic                    conv_valid = 1'b0;
  logic [`ADSP_RAW_W-1:0]  conv_raw = '0;
  logic                    continuous_mode = 1'b1;
  logic                    timeout_en = 1'b0;
  logic                    cmd_busy = 1'b0;
  logic [`ADSP_BYTE_W-1:0] tx_byte = '0;
  logic                    tx_load = 1'b0;
  wire                     cs_n, sclk, din, sdo;
  logic                    pin, oe_n, ready_n, rx_valid, srst;
  logic [`ADSP_BYTE_W-1:0] rx_byte, rx_last;
  logic [23:0]             rx;
  int                      errors = 0, tests_run = 0, rx_cnt = 0, srst_cnt = 0, n0;

  always #4 sys_clk = ~sys_clk;
  assign sdo = oe_n ? 1'bz : pin;

  adsp_port #(.TMO_CYC(256)) dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .cs_n(cs_n), .sclk(sclk), .din(din),
    .shared_out_ready_pin(pin), .shared_out_ready_oe_n(oe_n), .result_ready_n(ready_n),
    .conv_valid(conv_valid), .conv_raw(conv_raw), .continuous_mode(continuous_mode),
    .timeout_en(timeout_en), .cmd_busy(cmd_busy), .tx_byte(tx_byte), .tx_load(tx_load),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .serial_reset(srst));

  adsp_host host (.cs_n(cs_n), .sclk(sclk), .din(din), .sdo(sdo));

  always @(posedge sys_clk) begin
    if (rx_valid === 1'b1) begin
      rx_cnt++;
      rx_last <= rx_byte;
    end
    if (srst === 1'b1) srst_cnt++;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  task automatic pulse(input logic [`ADSP_RAW_W-1:0] raw);
    @(posedge sys_clk);
    conv_valid <= 1'b1;
    conv_raw   <= raw;
    @(posedge sys_clk);
    conv_valid <= 1'b0;
  endtask : pulse

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_result(input logic [`ADSP_RAW_W-1:0] raw, input logic [23:0] exp);
    int n;
    pulse(raw);
    @(posedge sys_clk);
    #1;
    check({23'h0, ready_n}, 24'h1);
    n = 1;
    while (ready_n !== 1'b0 && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(n[23:0], 24'(`ADSP_LEAD_CYC));
    if (n >= 40) finish_test();
    check({22'h0, oe_n, pin}, 24'h0);
    host.shift(24, 24'h0, rx);
    check(rx, exp);
    check({23'h0, ready_n}, 24'h1);
    $display("result test done");
  endtask : t_result

  task automatic t_desel();
    host.sel(1'b1);
    pulse(28'h0000123);
    repeat (27) @(posedge sys_clk);
    #1;
    check({22'h0, ready_n, oe_n}, 24'h1);
    n0 = rx_cnt;
    host.shift(8, 24'hA5, rx);
    repeat (10) @(posedge sys_clk);
    check(rx_cnt[23:0], n0[23:0]);
    $display("deselect test done");
  endtask : t_desel

  task automatic t_bytes();
    host.sel(1'b0);
    n0 = rx_cnt;
    host.shift(8, 24'hA5, rx);
    repeat (10) @(posedge sys_clk);
    check({rx_cnt[15:0] - n0[15:0], rx_last}, 24'h0001A5);
    host.shift(8, 24'h00, rx);
    repeat (10) @(posedge sys_clk);
    check(rx_cnt[23:0] - n0[23:0], 24'd1);
    $display("byte test done");
  endtask : t_bytes

  task automatic t_busy();
    @(posedge sys_clk);
    tx_byte  <= 8'h3C;
    tx_load  <= 1'b1;
    cmd_busy <= 1'b1;
    @(posedge sys_clk);
    tx_load <= 1'b0;
    pulse(28'h0000055);
    repeat (30) @(posedge sys_clk);
    host.shift(8, 24'h0, rx);
    check(rx, 24'h00003C);
    @(posedge sys_clk);
    cmd_busy <= 1'b0;
    $display("busy test done");
  endtask : t_busy

  task automatic t_single();
    @(posedge sys_clk);
    continuous_mode <= 1'b0;
    pulse(28'h0000777);
    repeat (26) @(posedge sys_clk);
    #1;
    check({23'h0, ready_n}, 24'h0);
    host.shift(24, 24'h0, rx);
    check(rx, 24'h000777);
    check({23'h0, ready_n}, 24'h0);
    @(posedge sys_clk);
    continuous_mode <= 1'b1;
    $display("single test done");
  endtask : t_single

  task automatic t_timeout();
    int n;
    @(posedge sys_clk);
    timeout_en <= 1'b1;
    n0 = srst_cnt;
    host.shift(4, 24'hF, rx);
    n = 0;
    while (srst_cnt == n0 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    check({23'h0, srst_cnt != n0}, 24'h1);
    if (n >= 400) finish_test();
    repeat (4) @(posedge sys_clk);
    n0 = rx_cnt;
    host.shift(8, 24'h5A, rx);
    repeat (10) @(posedge sys_clk);
    check({rx_cnt[15:0] - n0[15:0], rx_last}, 24'h00015A);
    timeout_en <= 1'b0;
    @(posedge sys_clk);
    n0 = srst_cnt;
    repeat (600) @(posedge sys_clk);
    check(srst_cnt[23:0], n0[23:0]);
    $display("timeout test done");
  endtask : t_timeout

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [`ADSP_RAW_W-1:0] raw [4] = '{28'h0800000, 28'hF7FFFFF, 28'hFFFFFFF, 28'h0000001};
    logic [23:0]            exp [4] = '{24'h7FFFFF, 24'h800000, 24'hFFFFFF, 24'h000001};
    repeat (19) @(posedge sys_clk);
    #1;
    check({21'h0, ready_n, oe_n, rx_valid}, 24'h6);
    @(posedge sys_clk);
    rst_b <= 1'b1;
    host.sel(1'b0);
    for (int i = 0; i < 4; i++) t_result(raw[i], exp[i]);
    pulse(28'h0000321);
    t_result(28'h0000456, 24'h000456);
    t_desel();
    t_bytes();
    t_busy();
    t_single();
    t_timeout();
    finish_test();
  end
endmodule : adsp_port_test
